// ===== acm_pkg.sv
`default_nettype none
package acm_pkg;

  // Full width of the violation vector
  localparam int FLAG_W = 94;
  // Positions watched by this block
  localparam int POS_FIRST = 77;
  localparam int NUM_POS = 17;
  localparam int POS_RUSER = 77;
  localparam int POS_RD_OVF = 78;
  localparam int POS_RD_UNF = 79;
  localparam int POS_WR_OVF = 80;
  localparam int POS_WR_UNF = 81;
  localparam int POS_EX_OVF = 82;
  localparam int POS_LITE_B = 83;
  localparam int POS_LITE_R = 84;
  localparam int POS_LITE_W = 85;
  localparam int POS_AW_NSZ = 86;
  localparam int POS_AR_NSZ = 87;
  localparam int POS_AW_NCA = 88;
  localparam int POS_AR_NCA = 89;
  localparam int POS_AW_LEN = 90;
  localparam int POS_AR_LEN = 91;
  localparam int POS_AWRDY = 92;
  localparam int POS_WRDY = 93;

  // Register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_COUNT = 12'h008;

  // Control fields and reset values
  localparam int CTRL_NARROW_BIT = 0;
  localparam int CTRL_MAXLEN_LSB = 8;
  localparam logic CTRL_NARROW_RST = 1'h1;
  localparam logic [7:0] CTRL_MAXLEN_RST = 8'hff;

  // Count register fields
  localparam int CNT_RD_LSB = 0;
  localparam int CNT_WR_LSB = 8;
  localparam int CNT_EX_LSB = 16;

  // Link encodings and allowed lite widths
  localparam logic [1:0] RESP_EXOKAY = 2'h1;
  localparam int CACHE_MOD_BIT = 1;
  localparam int LITE_W_A = 32;
  localparam int LITE_W_B = 64;

  // Monitored protocol
  typedef enum logic [1:0] {
    ACM_AXI4 = 2'h0,
    ACM_AXI3 = 2'h1,
    ACM_LITE = 2'h3
  } acm_proto_e;

endpackage
`default_nettype wire

// ===== acm_trk_if.sv
`timescale 1ns/1ns
`default_nettype none
// Request and status lines between the monitor and one tracker
interface acm_trk_if #(parameter int CW = 4);
  logic add;
  logic del;
  logic ovf;
  logic unf;
  logic [CW-1:0] count;
  modport owner(output add, output del, input ovf, input unf, input count);
  modport tracker(input add, input del, output ovf, output unf, output count);
endinterface
`default_nettype wire

// ===== acm_tracker.sv
`timescale 1ns/1ns
`default_nettype none
module acm_tracker #(
  parameter int DEPTH = 8,
  parameter int CW = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Add and remove requests, overflow and underflow pulses
  acm_trk_if.tracker trk
);

  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;

  // Clamp at both ends so a broken link cannot wrap the count
  always_comb begin
    count_next = count_reg;
    trk.ovf = 1'b0;
    trk.unf = 1'b0;
    if (trk.add && !trk.del) begin
      if (count_reg == FULL) begin
        trk.ovf = 1'b1;
      end else begin
        count_next = count_reg + 1'b1;
      end
    end else if (trk.del && !trk.add) begin
      if (count_reg == '0) begin
        trk.unf = 1'b1;
      end else begin
        count_next = count_reg - 1'b1;
      end
    end
  end

  // Count register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign trk.count = count_reg;

endmodule
`default_nettype wire

// ===== acm_monitor.sv
// Notes on behaviour
// - Each violation sets its own numbered bit of the status vector only.
// - Bit 77: read user field changes while read data waits, full AXI only.
// - Bits 78/79: read tracker overflow beyond its depth, and underflow.
// - Bits 80/81: write tracker overflow beyond its depth, and underflow.
// - Bit 82: exclusive tracker overflow, full AXI only.
// - Bits 83/84: lite slave gives EXOKAY on write or read response.
// - Bit 85: lite link with data width other than 32 or 64.
// - Lightweight build keeps only bits 78 and 80 here.
// - Bit 86: narrow write burst size when narrow transfers unsupported.
// - Bit 87: narrow read burst size when narrow transfers unsupported.
// - Bit 88: write burst without modifiable cache when narrow unsupported.
// - Bit 89: read burst without modifiable cache when narrow unsupported.
// - Bit 90: write burst length above the configured maximum.
// - Bit 91: read burst length above the configured maximum.
// - Bit 92: write address ready high in first cycle after reset.
// - Bit 93: write data ready high in first cycle after reset.
`timescale 1ns/1ns
`default_nettype none
module acm_monitor #(
  parameter acm_pkg::acm_proto_e PROTOCOL = acm_pkg::ACM_AXI4,
  parameter int DATA_WIDTH = 32,
  parameter int USER_W = 1,
  parameter int read_tracker_depth = 8,
  parameter int write_tracker_depth = 8,
  parameter int EXCL_DEPTH = 4,
  parameter bit LIGHTWEIGHT = 1'b0
) (
  // Clock and reset, shared with the monitored link
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Write address channel
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [7:0] awlen,
  input wire logic [2:0] awsize,
  input wire logic [3:0] awcache,
  input wire logic awlock,
  // Write data channel
  input wire logic wready,
  // Write response channel
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  // Read address channel
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [7:0] arlen,
  input wire logic [2:0] arsize,
  input wire logic [3:0] arcache,
  input wire logic arlock,
  // Read data channel
  input wire logic rvalid,
  input wire logic rready,
  input wire logic rlast,
  input wire logic [1:0] rresp,
  input wire logic [USER_W-1:0] ruser,
  // Violation status
  output logic [acm_pkg::FLAG_W-1:0] violation_flag_vector
);

  // Build-time check selection
  localparam bit IS_LITE = (PROTOCOL == acm_pkg::ACM_LITE);
  localparam bit CHK_FULL = !LIGHTWEIGHT;
  localparam bit CHK_AXI = CHK_FULL && !IS_LITE;
  localparam bit CHK_LITE = CHK_FULL && IS_LITE;
  localparam bit BAD_WIDTH = (DATA_WIDTH != acm_pkg::LITE_W_A)
    && (DATA_WIDTH != acm_pkg::LITE_W_B);
  localparam logic [2:0] FULL_SIZE = 3'($clog2(DATA_WIDTH / 8));
  localparam int RD_CW = $clog2(read_tracker_depth + 1);
  localparam int WR_CW = $clog2(write_tracker_depth + 1);
  localparam int EX_CW = $clog2(EXCL_DEPTH + 1);
  localparam logic [RD_CW-1:0] RD_FULL = RD_CW'(read_tracker_depth);
  localparam logic [WR_CW-1:0] WR_FULL = WR_CW'(write_tracker_depth);

  // Bit indices inside the local flag register
  localparam int I_RUSER = acm_pkg::POS_RUSER - acm_pkg::POS_FIRST;
  localparam int I_RD_OVF = acm_pkg::POS_RD_OVF - acm_pkg::POS_FIRST;
  localparam int I_RD_UNF = acm_pkg::POS_RD_UNF - acm_pkg::POS_FIRST;
  localparam int I_WR_OVF = acm_pkg::POS_WR_OVF - acm_pkg::POS_FIRST;
  localparam int I_WR_UNF = acm_pkg::POS_WR_UNF - acm_pkg::POS_FIRST;
  localparam int I_EX_OVF = acm_pkg::POS_EX_OVF - acm_pkg::POS_FIRST;
  localparam int I_LITE_B = acm_pkg::POS_LITE_B - acm_pkg::POS_FIRST;
  localparam int I_LITE_R = acm_pkg::POS_LITE_R - acm_pkg::POS_FIRST;
  localparam int I_LITE_W = acm_pkg::POS_LITE_W - acm_pkg::POS_FIRST;
  localparam int I_AW_NSZ = acm_pkg::POS_AW_NSZ - acm_pkg::POS_FIRST;
  localparam int I_AR_NSZ = acm_pkg::POS_AR_NSZ - acm_pkg::POS_FIRST;
  localparam int I_AW_NCA = acm_pkg::POS_AW_NCA - acm_pkg::POS_FIRST;
  localparam int I_AR_NCA = acm_pkg::POS_AR_NCA - acm_pkg::POS_FIRST;
  localparam int I_AW_LEN = acm_pkg::POS_AW_LEN - acm_pkg::POS_FIRST;
  localparam int I_AR_LEN = acm_pkg::POS_AR_LEN - acm_pkg::POS_FIRST;
  localparam int I_AWRDY = acm_pkg::POS_AWRDY - acm_pkg::POS_FIRST;
  localparam int I_WRDY = acm_pkg::POS_WRDY - acm_pkg::POS_FIRST;

  // Handshakes on the watched channels
  logic aw_hs;
  logic ar_hs;
  logic b_hs;
  logic r_hs;
  logic r_end;
  assign aw_hs = awvalid && awready;
  assign ar_hs = arvalid && arready;
  assign b_hs = bvalid && bready;
  assign r_hs = rvalid && rready;
  // A lite read has one beat, so every beat ends it
  assign r_end = r_hs && (IS_LITE || rlast);

  // Outstanding-transaction trackers
  acm_trk_if #(.CW(RD_CW)) rd_trk();
  acm_trk_if #(.CW(WR_CW)) wr_trk();
  acm_trk_if #(.CW(EX_CW)) ex_trk();

  // Reads leave on their last beat, writes on the response
  assign rd_trk.add = ar_hs;
  assign rd_trk.del = r_end;
  assign wr_trk.add = aw_hs;
  assign wr_trk.del = b_hs;
  // Exclusive reads wait for the exclusive write that pairs with them
  assign ex_trk.add = ar_hs && arlock;
  assign ex_trk.del = aw_hs && awlock;

  acm_tracker #(.DEPTH(read_tracker_depth), .CW(RD_CW)) u_rd_trk (
    .pclk(pclk),
    .presetn(presetn),
    .trk(rd_trk)
  );

  acm_tracker #(.DEPTH(write_tracker_depth), .CW(WR_CW)) u_wr_trk (
    .pclk(pclk),
    .presetn(presetn),
    .trk(wr_trk)
  );

  acm_tracker #(.DEPTH(EXCL_DEPTH), .CW(EX_CW)) u_ex_trk (
    .pclk(pclk),
    .presetn(presetn),
    .trk(ex_trk)
  );

  // State
  logic [acm_pkg::NUM_POS-1:0] flags_reg;
  logic [acm_pkg::NUM_POS-1:0] flags_next;
  logic [acm_pkg::NUM_POS-1:0] evt;
  logic [USER_W-1:0] ruser_reg;
  logic [USER_W-1:0] ruser_next;
  logic r_hold_reg;
  logic r_hold_next;
  logic first_reg;
  logic first_next;
  logic narrow_reg;
  logic narrow_next;
  logic [7:0] maxlen_reg;
  logic [7:0] maxlen_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic [31:0] rd_mux;
  logic wr_ctrl;
  logic mapped;

  // Violation events; each lands only on its own bit
  always_comb begin
    evt = '0;
    evt[I_RUSER] = CHK_AXI && r_hold_reg && (ruser != ruser_reg);
    evt[I_RD_OVF] = rd_trk.ovf;
    evt[I_RD_UNF] = CHK_FULL && rd_trk.unf;
    evt[I_WR_OVF] = wr_trk.ovf;
    evt[I_WR_UNF] = CHK_FULL && wr_trk.unf;
    evt[I_EX_OVF] = CHK_AXI && ex_trk.ovf;
    evt[I_LITE_B] = CHK_LITE && b_hs && (bresp == acm_pkg::RESP_EXOKAY);
    evt[I_LITE_R] = CHK_LITE && r_hs && (rresp == acm_pkg::RESP_EXOKAY);
    evt[I_LITE_W] = CHK_LITE && BAD_WIDTH;
    // Narrow and cache checks only matter for bursts
    if (CHK_AXI && !narrow_reg && aw_hs && (awlen != 8'h00)) begin
      evt[I_AW_NSZ] = (awsize < FULL_SIZE);
      evt[I_AW_NCA] = !awcache[acm_pkg::CACHE_MOD_BIT];
    end
    if (CHK_AXI && !narrow_reg && ar_hs && (arlen != 8'h00)) begin
      evt[I_AR_NSZ] = (arsize < FULL_SIZE);
      evt[I_AR_NCA] = !arcache[acm_pkg::CACHE_MOD_BIT];
    end
    evt[I_AW_LEN] = CHK_AXI && aw_hs && (awlen > maxlen_reg);
    evt[I_AR_LEN] = CHK_AXI && ar_hs && (arlen > maxlen_reg);
    // A ready that is high here could have lost a transfer in reset
    evt[I_AWRDY] = CHK_FULL && first_reg && awready;
    evt[I_WRDY] = CHK_FULL && first_reg && wready;
  end

  // Sticky flags: nothing but reset clears them
  assign flags_next = flags_reg | evt;
  // Remember the read data channel for the stability check
  assign ruser_next = ruser;
  assign r_hold_next = rvalid && !rready;
  // First-cycle marker drops after the first edge out of reset
  assign first_next = 1'b0;

  // Register decode
  always_comb begin
    mapped = 1'b1;
    rd_mux = '0;
    case (paddr)
      acm_pkg::OFS_CTRL: begin
        rd_mux[acm_pkg::CTRL_NARROW_BIT] = narrow_reg;
        rd_mux[acm_pkg::CTRL_MAXLEN_LSB +: 8] = maxlen_reg;
      end
      acm_pkg::OFS_STATUS: begin
        rd_mux[acm_pkg::NUM_POS-1:0] = flags_reg;
      end
      acm_pkg::OFS_COUNT: begin
        rd_mux[acm_pkg::CNT_RD_LSB +: 8] = 8'(rd_trk.count);
        rd_mux[acm_pkg::CNT_WR_LSB +: 8] = 8'(wr_trk.count);
        rd_mux[acm_pkg::CNT_EX_LSB +: 8] = 8'(ex_trk.count);
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // Control writes land in the access phase only
  assign wr_ctrl = psel && penable && pwrite && (paddr == acm_pkg::OFS_CTRL);

  always_comb begin
    narrow_next = narrow_reg;
    maxlen_next = maxlen_reg;
    if (wr_ctrl) begin
      narrow_next = pwdata[acm_pkg::CTRL_NARROW_BIT];
      maxlen_next = pwdata[acm_pkg::CTRL_MAXLEN_LSB +: 8];
    end
  end

  // Read data is caught in the setup phase so it leaves a flop
  assign prdata_next = (psel && !penable && !pwrite) ? rd_mux : prdata_reg;

  // All state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= '0;
      ruser_reg <= '0;
      r_hold_reg <= 1'b0;
      first_reg <= 1'b1;
      narrow_reg <= acm_pkg::CTRL_NARROW_RST;
      maxlen_reg <= acm_pkg::CTRL_MAXLEN_RST;
      prdata_reg <= 32'h0000_0000;
    end else begin
      flags_reg <= flags_next;
      ruser_reg <= ruser_next;
      r_hold_reg <= r_hold_next;
      first_reg <= first_next;
      narrow_reg <= narrow_next;
      maxlen_reg <= maxlen_next;
      prdata_reg <= prdata_next;
    end
  end

  // Zero-wait slave; unmapped offsets answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_reg;
  // Lower positions belong to other checks and read as zero here
  assign violation_flag_vector = {flags_reg, {acm_pkg::POS_FIRST{1'b0}}};

  // Checks on the block's own behaviour

  property p_ruser;
    @(posedge pclk) disable iff (!presetn)
      CHK_AXI && $past(rvalid) && !$past(rready) && (ruser != $past(ruser))
      |=> violation_flag_vector[acm_pkg::POS_RUSER];
  endproperty
  a_ruser: assert property (p_ruser) else $error("user change not flagged");

  property p_rd_ovf;
    @(posedge pclk) disable iff (!presetn)
      ar_hs && !r_end && (rd_trk.count == RD_FULL)
      |=> violation_flag_vector[acm_pkg::POS_RD_OVF];
  endproperty
  a_rd_ovf: assert property (p_rd_ovf) else $error("read overflow missed");

  property p_wr_unf;
    @(posedge pclk) disable iff (!presetn)
      CHK_FULL && b_hs && !aw_hs && (wr_trk.count == '0)
      |=> violation_flag_vector[acm_pkg::POS_WR_UNF];
  endproperty
  a_wr_unf: assert property (p_wr_unf) else $error("write underflow missed");

  property p_wr_ovf_cnt;
    @(posedge pclk) disable iff (!presetn)
      aw_hs && !b_hs && (wr_trk.count != WR_FULL)
      |=> (wr_trk.count == $past(wr_trk.count) + 1'b1);
  endproperty
  a_wr_ovf_cnt: assert property (p_wr_ovf_cnt) else $error("write count stuck");

  property p_lite_b;
    @(posedge pclk) disable iff (!presetn)
      CHK_LITE && b_hs && (bresp == acm_pkg::RESP_EXOKAY)
      |=> violation_flag_vector[acm_pkg::POS_LITE_B];
  endproperty
  a_lite_b: assert property (p_lite_b) else $error("lite write exokay missed");

  property p_ar_narrow;
    @(posedge pclk) disable iff (!presetn)
      CHK_AXI && !narrow_reg && ar_hs && (arlen != 8'h00) && (arsize < FULL_SIZE)
      |=> violation_flag_vector[acm_pkg::POS_AR_NSZ];
  endproperty
  a_ar_narrow: assert property (p_ar_narrow) else $error("narrow read missed");

  property p_aw_len;
    @(posedge pclk) disable iff (!presetn)
      CHK_AXI && aw_hs && (awlen > maxlen_reg)
      |=> violation_flag_vector[acm_pkg::POS_AW_LEN];
  endproperty
  a_aw_len: assert property (p_aw_len) else $error("write length missed");

  property p_awrdy;
    @(posedge pclk) disable iff (!presetn)
      CHK_FULL && first_reg && awready
      |=> violation_flag_vector[acm_pkg::POS_AWRDY] [*3];
  endproperty
  a_awrdy: assert property (p_awrdy) else $error("early ready missed");

  property p_sticky;
    @(posedge pclk) disable iff (!presetn)
      violation_flag_vector[acm_pkg::POS_WRDY]
      |=> violation_flag_vector[acm_pkg::POS_WRDY];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped");

  property p_light;
    @(posedge pclk) disable iff (!presetn)
      LIGHTWEIGHT |-> (flags_reg[I_RD_UNF] == 1'b0) && (flags_reg[I_AWRDY] == 1'b0);
  endproperty
  a_light: assert property (p_light) else $error("lightweight flag set");

endmodule
`default_nettype wire

// ===== acm_link_model.sv
`timescale 1ns/1ns
`default_nettype none
module acm_link_model (
  // Clock of the monitored link
  input wire logic pclk,
  // Write address channel
  output var logic awvalid,
  output var logic awready,
  output var logic [7:0] awlen,
  output var logic [2:0] awsize,
  output var logic [3:0] awcache,
  output var logic awlock,
  // Write data and response channels
  output var logic wready,
  output var logic bvalid,
  output var logic bready,
  output var logic [1:0] bresp,
  // Read address channel
  output var logic arvalid,
  output var logic arready,
  output var logic [7:0] arlen,
  output var logic [2:0] arsize,
  output var logic [3:0] arcache,
  output var logic arlock,
  // Read data channel
  output var logic rvalid,
  output var logic rready,
  output var logic rlast,
  output var logic [1:0] rresp,
  output var logic ruser
);
  // Every ready starts low, so nothing is lost while reset is on
  initial begin
    {awvalid, awready, awlen, awsize, awcache, awlock, wready} = '0;
    {bvalid, bready, bresp, arvalid, arready, arlen, arsize, arcache, arlock} = '0;
    {rvalid, rready, rlast, rresp, ruser} = '0;
  end

  // Address command; slow adds wait cycles before the slave accepts
  task automatic addr(input bit wr, input logic [7:0] len, input logic [2:0] sz,
                      input logic [3:0] ca, input logic lk, input int slow);
    @(posedge pclk);
    if (wr) begin
      {awvalid, awlen, awsize, awcache, awlock} <= {1'b1, len, sz, ca, lk};
    end else begin
      {arvalid, arlen, arsize, arcache, arlock} <= {1'b1, len, sz, ca, lk};
    end
    repeat (slow) @(posedge pclk);
    if (wr) begin
      awready <= 1'b1;
    end else begin
      arready <= 1'b1;
    end
    @(posedge pclk);
    {awvalid, awready, arvalid, arready} <= '0;
    // Released lines show the inverse, never a stale copy
    {awlen, awsize, awcache, awlock} <= ~{len, sz, ca, lk};
    {arlen, arsize, arcache, arlock} <= ~{len, sz, ca, lk};
  endtask

  // One write response, accepted at once
  task automatic b(input logic [1:0] resp);
    @(posedge pclk);
    {bvalid, bready, bresp} <= {2'b11, resp};
    @(posedge pclk);
    {bvalid, bready, bresp} <= {2'b00, ~resp};
  endtask

  // One read beat, accepted at once
  task automatic r(input logic [1:0] resp, input logic last);
    @(posedge pclk);
    {rvalid, rready, rresp, rlast} <= {2'b11, resp, last};
    @(posedge pclk);
    {rvalid, rready, rresp, rlast} <= {2'b00, ~resp, ~last};
  endtask

  // Faulty slave: user field moves while a beat is stalled
  task automatic r_stall();
    @(posedge pclk);
    {rvalid, rready, ruser} <= 3'b100;
    @(posedge pclk);
    ruser <= 1'b1;
    @(posedge pclk);
    rvalid <= 1'b0;
  endtask

  // Faulty slave: readys high at the edge right after reset release
  task automatic ready_at_release(input logic a, input logic w);
    awready <= a;
    wready <= w;
    @(posedge pclk);
    awready <= 1'b0;
    wready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== tb_acm_monitor.sv
`timescale 1ns/1ns
`default_nettype none
`define CHECK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, g, e); end end
module tb_acm_monitor;
  logic pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  wire logic [31:0] prd [3];
  wire logic rdy [3];
  wire logic err [3];
  wire logic [acm_pkg::FLAG_W-1:0] vec [3];
  wire logic awvalid, awready, awlock, wready, bvalid, bready, arvalid, arready, arlock;
  wire logic rvalid, rready, rlast, ruser;
  wire logic [7:0] awlen, arlen;
  wire logic [2:0] awsize, arsize;
  wire logic [3:0] awcache, arcache;
  wire logic [1:0] bresp, rresp;
  int fail_count = 0;
  int compares = 0;
  int cyc = 0;

  // Full, lite (odd width) and lightweight monitors watch the same link
  for (genvar g = 0; g < 3; g++) begin : g_mon
    acm_monitor #(
      .PROTOCOL(g == 1 ? acm_pkg::ACM_LITE : acm_pkg::ACM_AXI4),
      .DATA_WIDTH(g == 1 ? 48 : 32),
      .LIGHTWEIGHT(g == 2)
    ) i_acm_monitor (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prd[g]), .pready(rdy[g]),
      .pslverr(err[g]), .awvalid(awvalid), .awready(awready), .awlen(awlen),
      .awsize(awsize), .awcache(awcache), .awlock(awlock), .wready(wready),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .arlen(arlen), .arsize(arsize), .arcache(arcache),
      .arlock(arlock), .rvalid(rvalid), .rready(rready), .rlast(rlast), .rresp(rresp),
      .ruser(ruser), .violation_flag_vector(vec[g])
    );
  end

  acm_link_model i_acm_link_model (
    .pclk(pclk), .awvalid(awvalid), .awready(awready), .awlen(awlen), .awsize(awsize),
    .awcache(awcache), .awlock(awlock), .wready(wready), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .arlen(arlen), .arsize(arsize), .arcache(arcache), .arlock(arlock),
    .rvalid(rvalid), .rready(rready), .rlast(rlast), .rresp(rresp), .ruser(ruser)
  );

  function automatic logic [16:0] m(input int p);
    return 17'h1 << (p - acm_pkg::POS_FIRST);
  endfunction

  task automatic test_done();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // APB master; waits for pready only, the cycle ceiling ends a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int waits;
    waits = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      waits++;
    end while (rdy[0] !== 1'b1);
    q = prd[0];
    e = err[0];
    {psel, penable} <= 2'b00;
    // Zero-wait slave: the first access edge must already see pready
    `CHECK(waits, 1)
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    `CHECK({e, q}, {1'b0, exp})
  endtask

  // Flags are read at a falling edge, well clear of their update
  task automatic fl(input int g, input logic [16:0] e);
    repeat (2) @(negedge pclk);
    `CHECK(vec[g][acm_pkg::POS_WRDY:acm_pkg::POS_FIRST], e)
  endtask

  task automatic rst(input logic a, input logic w);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    i_acm_link_model.ready_at_release(a, w);
  endtask

  task automatic t_regs();
    logic [31:0] q;
    logic e;
    rd(acm_pkg::OFS_CTRL, 32'h0000ff01);
    wr(acm_pkg::OFS_STATUS, 32'hffffffff);
    rd(acm_pkg::OFS_STATUS, 32'h00000000);
    rd(acm_pkg::OFS_COUNT, 32'h00000000);
    apb(1'b0, 12'h00c, 32'h0, q, e);
    `CHECK({e, q}, 33'h100000000)
    `CHECK(vec[0], {acm_pkg::FLAG_W{1'b0}})
    $display("t_regs done");
  endtask

  task automatic t_len();
    rst(1'b0, 1'b0);
    wr(acm_pkg::OFS_CTRL, 32'h00000301);
    i_acm_link_model.addr(1'b1, 8'h03, 3'h2, 4'h2, 1'b0, 0);
    fl(0, 17'h0);
    i_acm_link_model.addr(1'b1, 8'h04, 3'h2, 4'h2, 1'b0, 2);
    i_acm_link_model.addr(1'b0, 8'h04, 3'h2, 4'h2, 1'b0, 1);
    fl(0, m(90) | m(91));
    rd(acm_pkg::OFS_STATUS, 32'h00006000);
    rd(acm_pkg::OFS_COUNT, 32'h00000201);
    i_acm_link_model.b(2'h0);
    i_acm_link_model.b(2'h0);
    i_acm_link_model.r(2'h0, 1'b0);
    rd(acm_pkg::OFS_COUNT, 32'h00000001);
    i_acm_link_model.r(2'h0, 1'b1);
    rd(acm_pkg::OFS_COUNT, 32'h00000000);
    fl(0, m(90) | m(91));
    $display("t_len done");
  endtask

  // Accumulating table: a zero-length narrow command must stay clean
  task automatic t_narrow();
    bit w [5] = '{1, 1, 0, 1, 0};
    logic [2:0] s [5] = '{3'h0, 3'h1, 3'h2, 3'h2, 3'h0};
    logic [3:0] c [5] = '{4'h0, 4'h2, 4'h0, 4'h0, 4'h2};
    int p [5] = '{0, 86, 89, 88, 87};
    logic [16:0] e;
    rst(1'b0, 1'b0);
    wr(acm_pkg::OFS_CTRL, 32'h0000ff00);
    e = 17'h0;
    foreach (p[i]) begin
      i_acm_link_model.addr(w[i], (i == 0) ? 8'h00 : 8'h01, s[i], c[i], 1'b0, i);
      e |= (p[i] != 0) ? m(p[i]) : 17'h0;
      fl(0, e);
    end
    $display("t_narrow done");
  endtask

  task automatic t_track();
    rst(1'b0, 1'b0);
    repeat (9) i_acm_link_model.addr(1'b0, 8'h00, 3'h2, 4'h2, 1'b0, 0);
    repeat (9) i_acm_link_model.addr(1'b1, 8'h00, 3'h2, 4'h2, 1'b0, 0);
    fl(0, m(78) | m(80));
    fl(2, m(78) | m(80));
    rd(acm_pkg::OFS_COUNT, 32'h00000808);
    rst(1'b0, 1'b0);
    i_acm_link_model.r(2'h0, 1'b1);
    i_acm_link_model.b(2'h0);
    fl(0, m(79) | m(81));
    fl(2, 17'h0);
    $display("t_track done");
  endtask

  task automatic t_misc();
    rst(1'b0, 1'b0);
    i_acm_link_model.r_stall();
    repeat (5) i_acm_link_model.addr(1'b0, 8'h00, 3'h2, 4'h2, 1'b1, 1);
    i_acm_link_model.r(acm_pkg::RESP_EXOKAY, 1'b1);
    i_acm_link_model.b(acm_pkg::RESP_EXOKAY);
    fl(0, m(77) | m(81) | m(82));
    fl(1, m(81) | m(83) | m(84) | m(85));
    $display("t_misc done");
  endtask

  task automatic t_ready();
    rst(1'b1, 1'b0);
    fl(0, m(92));
    rst(1'b0, 1'b1);
    fl(0, m(93));
    fl(1, m(85) | m(93));
    $display("t_ready done");
  endtask

  // Free-running clock, 10 ns period
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Cycle ceiling; the whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      test_done();
    end
  end

  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    rst(1'b0, 1'b0);
    t_regs();
    t_len();
    t_narrow();
    t_track();
    t_misc();
    t_ready();
    test_done();
  end
endmodule
`default_nettype wire
